// ===== core/fsp_status_reg.sv
// Status and protection register bank of a serial flash device.
// Assumes a command decoder ahead of it delivering one-cycle strobes,
// at most one per clock, and an array engine that reports completion.
//
// Contract
// - Status word reads as low byte bits 7..0 and high byte bits 15..8.
// - Busy bit is 1 during program, erase or status write, else 0.
// - Bit 1 shows write-enable latch; clear latch refuses writes, program, erase.
// - Five non-volatile protect bits 6..2 block program and erases in their region.
// - Protect bits change only through the status write command.
// - Chip erase only if low protect bits 000 with cmp 0 or 111 with cmp 1.
// - Lock bits 8 and 7 are non-volatile read/write, choose write protection method.
// - Lock bits 00: status write accepted whenever write-enable latch set; the code also refuses it while busy.
// - Lock bits 10: status writes refused until power cycle, which returns 00.
// - Lock bits 11: status writes refused forever; special-order option only.
// - Quad bit 9 reads 1 always, writes ignored, upper data pins enabled.
// - Security lock bits 13..11 reset 0, each settable to 1 by status write.
// - A set security lock bit never clears; security registers become read-only.
// - Complement bit 14 non-volatile, default 0, combines with protect bits.
// - Suspend sets bit 15 for suspended erase, bit 10 for suspended program.
// - Resume, software reset or power cycle clears both suspend flags.
// - Suspend flags are read-only; status writes leave them unchanged.
// - Write-enable command sets the write-enable latch.
// - Latch clears on power-up, reset, disable, status write, program, erases.
`timescale 1ns/1ps
`default_nettype none

module fsp_status_reg
  import fsp_pkg::*;
#(
  parameter int   ADDR_W     = 24,
  parameter int   SRW_CYCLES = fsp_pkg::SRW_CYCLES_DEF,
  parameter logic OTP_OPTION = 1'b1
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // Reset and power events
  input  wire logic                  reset_pin_event,
  input  wire logic                  soft_reset_event,
  input  wire logic                  power_cycle_event,
  // Decoded commands
  input  wire logic                  write_enable_cmd,
  input  wire logic                  write_disable_cmd,
  input  wire logic                  status_write_cmd,
  input  wire logic [15:0]           status_write_data,
  input  wire logic                  page_program_cmd,
  input  wire logic                  sector_erase_cmd,
  input  wire logic                  block_erase_cmd,
  input  wire logic                  chip_erase_cmd,
  input  wire logic [ADDR_W-1:0]     cmd_addr,
  input  wire logic                  suspend_cmd,
  input  wire logic                  resume_cmd,
  // Array engine
  input  wire logic                  engine_done,
  output logic                       op_start,
  output fsp_pkg::fsp_kind_e         op_kind,
  output logic [ADDR_W-1:0]          op_addr,
  output logic                       op_suspend,
  output logic                       op_resume,
  // Status readback and side outputs
  output logic [7:0]                 status_low,
  output logic [7:0]                 status_high,
  output logic                       upper_pins_enabled,
  output logic [2:0]                 secure_regs_read_only
);
  import fsp_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE, ST_SRW} fsp_state_e;

  localparam int CNT_W = $clog2(SRW_CYCLES + 1);
  localparam logic [CNT_W-1:0] SRW_LAST = CNT_W'(SRW_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // ==========================================================
  // State
  fsp_state_e        state_q, state_d;
  logic              write_enable_latch_q;
  logic [4:0]        protect_field_q;
  logic [1:0]        reg_lock_q;
  logic [2:0]        secure_lock_q;
  logic              complement_protect_q;
  logic              erase_suspended_q;
  logic              program_suspended_q;
  logic [CNT_W-1:0]  srw_cnt_q;
  logic              op_start_q;
  fsp_kind_e         op_kind_q;
  logic [ADDR_W-1:0] op_addr_q;
  logic              op_suspend_q;
  logic              op_resume_q;
  logic              quad_enable_q;
  logic              busy_q;

  // ==========================================================
  // Protected-region decode
  function automatic logic in_region(input logic [4:0]        bp,
                                     input logic              cmp,
                                     input logic [ADDR_W-1:0] addr);
    logic [2:0]        n;
    logic [2:0]        nt;
    int                e;
    logic [ADDR_W-1:0] mask;
    logic              hit;
    n    = bp[2:0];
    nt   = (n > TOP_BLK_MAX) ? TOP_BLK_MAX : n;
    e    = bp[4] ? (TOP_BLK_EXP + int'(nt)) : (ADDR_W - BP_FRAC_BASE + int'(n));
    mask = {ADDR_W{1'b1}} << e;
    if (n == BP_LOW_NONE) begin
      hit = 1'b0;
    end else if (n == BP_LOW_ALL) begin
      hit = 1'b1;
    end else if (bp[3]) begin
      hit = ((addr & mask) == '0);
    end else begin
      hit = ((addr & mask) == mask);
    end
    // Complement flips the protected set
    in_region = hit ^ cmp;
  endfunction

  // ==========================================================
  // Command decode
  wire idle        = (state_q == ST_IDLE);
  wire busy_flag   = busy_q;
  wire any_reset   = reset_pin_event | soft_reset_event | power_cycle_event;
  wire addr_locked = in_region(protect_field_q, complement_protect_q, cmd_addr);
  wire addr_op     = page_program_cmd | sector_erase_cmd | block_erase_cmd;
  wire ce_allowed  = (protect_field_q[2:0] == BP_LOW_NONE && !complement_protect_q) ||
                     (protect_field_q[2:0] == BP_LOW_ALL && complement_protect_q);
  wire srw_locked  = (reg_lock_q == LOCK_SUPPLY) || (reg_lock_q == LOCK_OTP);
  wire gate_ok     = idle && write_enable_latch_q;
  wire srw_take    = status_write_cmd && gate_ok && !srw_locked;
  wire addr_take   = addr_op && gate_ok && !addr_locked;
  wire ce_take     = chip_erase_cmd && gate_ok && ce_allowed;
  wire op_take     = addr_take || ce_take;
  wire wel_clear   = any_reset || write_disable_cmd ||
                     ((status_write_cmd || addr_op || chip_erase_cmd) && gate_ok);
  wire susp_erase  = suspend_cmd && (state_q == ST_ERASE);
  wire susp_prog   = suspend_cmd && (state_q == ST_PROG);
  wire resume_ok   = resume_cmd && idle && (erase_suspended_q || program_suspended_q);
  wire srw_end     = (state_q == ST_SRW) && (srw_cnt_q == SRW_LAST);
  wire [1:0] lock_new = status_write_data[BIT_LOCK_HI:BIT_LOCK_LO];
  wire lock_wr_ok  = OTP_OPTION || (lock_new != LOCK_OTP);

  wire fsp_kind_e kind_now = page_program_cmd ? KIND_PROG   :
                             sector_erase_cmd ? KIND_SECTOR :
                             block_erase_cmd  ? KIND_BLOCK  : KIND_CHIP;

  // ==========================================================
  // Busy sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (srw_take) begin
          state_d = ST_SRW;
        end else if (op_take) begin
          state_d = (kind_now == KIND_PROG) ? ST_PROG : ST_ERASE;
        end else if (resume_ok) begin
          state_d = program_suspended_q ? ST_PROG : ST_ERASE;
        end
      end
      ST_PROG, ST_ERASE: begin
        if (engine_done || suspend_cmd) begin
          state_d = ST_IDLE;
        end
      end
      ST_SRW: begin
        if (srw_end) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Reset events abort whatever runs
    if (soft_reset_event || reset_pin_event || power_cycle_event) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      srw_cnt_q <= CNT_ZERO;
      busy_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      // Same timing as state_q, but the status bit leaves a flop
      busy_q    <= (state_d != ST_IDLE);
      srw_cnt_q <= (state_q == ST_SRW && !srw_end) ? srw_cnt_q + 1'b1 : CNT_ZERO;
    end
  end

  // ==========================================================
  // Write-enable latch
  always_ff @(posedge clock) begin
    if (reset) begin
      write_enable_latch_q <= 1'b0;
    end else if (wel_clear) begin
      write_enable_latch_q <= 1'b0;
    end else if (write_enable_cmd) begin
      write_enable_latch_q <= 1'b1;
    end
  end

  // ==========================================================
  // Non-volatile fields; reset stands for a blank part
  always_ff @(posedge clock) begin
    if (reset) begin
      protect_field_q      <= BP_RESET;
      reg_lock_q           <= LOCK_RESET;
      secure_lock_q        <= SEC_RESET;
      complement_protect_q <= CMP_RESET;
    end else if (srw_take) begin
      protect_field_q      <= status_write_data[BIT_BP_HI:BIT_BP_LO];
      reg_lock_q           <= lock_wr_ok ? lock_new : reg_lock_q;
      secure_lock_q        <= secure_lock_q | status_write_data[BIT_SEC_HI:BIT_SEC_LO];
      complement_protect_q <= status_write_data[BIT_CMP];
    end else if (power_cycle_event && reg_lock_q == LOCK_SUPPLY) begin
      reg_lock_q           <= LOCK_SW;
    end
  end

  // ==========================================================
  // Suspend flags, read-only to the host
  always_ff @(posedge clock) begin
    if (reset) begin
      erase_suspended_q   <= 1'b0;
      program_suspended_q <= 1'b0;
    end else if (any_reset || resume_ok) begin
      erase_suspended_q   <= 1'b0;
      program_suspended_q <= 1'b0;
    end else begin
      erase_suspended_q   <= erase_suspended_q | susp_erase;
      program_suspended_q <= program_suspended_q | susp_prog;
    end
  end

  // ==========================================================
  // Engine handshake, all registered
  always_ff @(posedge clock) begin
    if (reset) begin
      op_start_q    <= 1'b0;
      op_kind_q     <= KIND_PROG;
      op_addr_q     <= '0;
      op_suspend_q  <= 1'b0;
      op_resume_q   <= 1'b0;
      quad_enable_q <= QE_VALUE;
    end else begin
      op_start_q    <= op_take && !srw_take && !any_reset;
      op_suspend_q  <= (susp_erase || susp_prog) && !any_reset;
      op_resume_q   <= resume_ok && !any_reset;
      quad_enable_q <= QE_VALUE;
      if (op_take) begin
        op_kind_q <= kind_now;
        op_addr_q <= cmd_addr;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign op_start              = op_start_q;
  assign op_kind               = op_kind_q;
  assign op_addr               = op_addr_q;
  assign op_suspend            = op_suspend_q;
  assign op_resume             = op_resume_q;
  assign upper_pins_enabled    = quad_enable_q;
  assign secure_regs_read_only = secure_lock_q;
  assign status_low  = {reg_lock_q[0], protect_field_q, write_enable_latch_q,
                        busy_flag};
  assign status_high = {erase_suspended_q, complement_protect_q, secure_lock_q,
                        program_suspended_q, quad_enable_q, reg_lock_q[1]};

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence srw_accepted_s;
    status_write_cmd && gate_ok && !srw_locked;
  endsequence

  sequence srw_busy_s;
    status_low[BIT_BUSY] [*8];
  endsequence

  wel_gate_a: assert property ((status_write_cmd || addr_op || chip_erase_cmd)
      && !status_low[BIT_WEL] |=> !op_start && $stable(protect_field_q))
    else $error("write accepted with latch clear");

  busy_srw_a: assert property (srw_accepted_s |=> srw_busy_s)
    else $error("busy not held during status write");

  busy_op_a: assert property (op_take && !any_reset |=> op_start && status_low[BIT_BUSY])
    else $error("accepted operation did not start busy");

  protect_block_a: assert property (addr_op && addr_locked |=> !op_start)
    else $error("operation ran in protected region");

  bp_only_srw_a: assert property (!srw_take |=> $stable(protect_field_q))
    else $error("protect field changed outside status write");

  chip_gate_a: assert property (chip_erase_cmd && !ce_allowed |=> !op_start)
    else $error("chip erase ran under protection");

  lock_supply_a: assert property (reg_lock_q == LOCK_SUPPLY && !power_cycle_event
      |=> reg_lock_q == LOCK_SUPPLY && $stable(status_high[6:3])
      && $stable(protect_field_q))
    else $error("supply lock-down not held");

  lock_otp_a: assert property (reg_lock_q == LOCK_OTP |=> reg_lock_q == LOCK_OTP)
    else $error("one-time lock released");

  supply_release_a: assert property (power_cycle_event && reg_lock_q == LOCK_SUPPLY
      && !srw_take |=> reg_lock_q == LOCK_SW)
    else $error("power cycle did not release lock");

  quad_fixed_a: assert property (status_high[BIT_QE - BYTE_W] && upper_pins_enabled)
    else $error("quad enable not one");

  secure_sticky_a: assert property ((secure_lock_q & ~$past(secure_lock_q)) == 3'h0
      || srw_take || $past(srw_take) )
    else $error("security lock set without status write");

  secure_keep_a: assert property (($past(secure_lock_q) & ~secure_lock_q) == 3'h0)
    else $error("security lock cleared");

  susp_set_a: assert property (susp_erase && !any_reset |=> status_high[BIT_ESUS - BYTE_W]
      && !status_low[BIT_BUSY])
    else $error("erase suspend flag not set");

  susp_clear_a: assert property ((resume_ok || any_reset) |=> !status_high[BIT_ESUS - BYTE_W]
      && !status_high[BIT_PSUS - BYTE_W])
    else $error("suspend flags not cleared");

  susp_ro_a: assert property (srw_take && !suspend_cmd
      |=> $stable(erase_suspended_q) && $stable(program_suspended_q))
    else $error("status write changed suspend flags");

  wel_set_a: assert property (write_enable_cmd && !wel_clear |=> status_low[BIT_WEL])
    else $error("write enable did not set latch");

  wel_clear_a: assert property (wel_clear |=> !status_low[BIT_WEL])
    else $error("latch not cleared");

endmodule

`default_nettype wire

// ===== pkg/fsp_pkg.sv
// Constants for the flash status and protection register bank.
// Assumes one decoded command strobe per clock from the command decoder.
package fsp_pkg;

  // ==========================================================
  // Bit positions within the 16-bit status word
  localparam int BIT_BUSY      = 0;
  localparam int BIT_WEL       = 1;
  localparam int BIT_BP_LO     = 2;
  localparam int BIT_BP_HI     = 6;
  localparam int BIT_LOCK_LO   = 7;
  localparam int BIT_LOCK_HI   = 8;
  localparam int BIT_QE        = 9;
  localparam int BIT_PSUS      = 10;
  localparam int BIT_SEC_LO    = 11;
  localparam int BIT_SEC_HI    = 13;
  localparam int BIT_CMP       = 14;
  localparam int BIT_ESUS      = 15;
  localparam int BYTE_W        = 8;

  // ==========================================================
  // Reset values and fixed encodings
  localparam logic [4:0] BP_RESET     = 5'h00;
  localparam logic [1:0] LOCK_RESET   = 2'h0;
  localparam logic [1:0] LOCK_SW      = 2'h0;
  localparam logic [1:0] LOCK_SUPPLY  = 2'h2;
  localparam logic [1:0] LOCK_OTP     = 2'h3;
  localparam logic [2:0] SEC_RESET    = 3'h0;
  localparam logic       CMP_RESET    = 1'h0;
  localparam logic       QE_VALUE     = 1'h1;
  localparam logic [2:0] BP_LOW_NONE  = 3'h0;
  localparam logic [2:0] BP_LOW_ALL   = 3'h7;
  localparam int         BP_FRAC_BASE = 7;
  localparam int         TOP_BLK_EXP  = 11;
  localparam logic [2:0] TOP_BLK_MAX  = 3'h4;

  // ==========================================================
  // Timing
  localparam int SRW_CYCLES_DEF = 16;

  // Operation handed to the array engine
  typedef enum logic [1:0] {
    KIND_PROG,
    KIND_SECTOR,
    KIND_BLOCK,
    KIND_CHIP
  } fsp_kind_e;

endpackage

// ===== verif/flash_status_protect_register_tb.sv
// Self-checking bench for the flash status and protection register bank.
// Assumes fsp_engine_model stands in for the array engine.
`timescale 1ns/1ps
`default_nettype none

module flash_status_protect_register_tb;
  import fsp_pkg::*;
  // =========================================================
  // Command strobe indices
  localparam int C_WRITE_ENABLE_CMD = 0, C_WRDI = 1, C_SRW = 2, C_PP = 3, C_SE = 4, C_BE = 5;
  localparam int C_CE = 6, C_SUS = 7, C_RES = 8, C_SOFT = 9, C_PIN = 10, C_PWR = 11;
  typedef struct {
    int          cmd;
    logic [15:0] data;
    logic [23:0] addr;
    logic [15:0] word;
    logic        start;
    logic [1:0]  kind;
  } fsp_row_s;

  logic        clock, reset, slow, engine_done, op_start, op_suspend, op_resume;
  logic        upper_pins_enabled;
  logic [11:0] strb;
  logic [15:0] wdata;
  logic [23:0] addr, op_addr, last_addr;
  logic [7:0]  status_low, status_high;
  logic [2:0]  secure_regs_read_only;
  logic [1:0]  last_kind;
  fsp_kind_e   op_kind;
  int          starts, base, suspends, mismatches, total_checks;
  fsp_row_s    rows [34];
  wire logic [15:0] word = {status_high, status_low};

  fsp_status_reg #(.SRW_CYCLES(8)) u_fsp_status_reg (
    .clock(clock), .reset(reset), .reset_pin_event(strb[C_PIN]),
    .soft_reset_event(strb[C_SOFT]), .power_cycle_event(strb[C_PWR]),
    .write_enable_cmd(strb[C_WRITE_ENABLE_CMD]), .write_disable_cmd(strb[C_WRDI]),
    .status_write_cmd(strb[C_SRW]), .status_write_data(wdata),
    .page_program_cmd(strb[C_PP]), .sector_erase_cmd(strb[C_SE]),
    .block_erase_cmd(strb[C_BE]), .chip_erase_cmd(strb[C_CE]), .cmd_addr(addr),
    .suspend_cmd(strb[C_SUS]), .resume_cmd(strb[C_RES]), .engine_done(engine_done),
    .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_suspend(op_suspend),
    .op_resume(op_resume), .status_low(status_low), .status_high(status_high),
    .upper_pins_enabled(upper_pins_enabled), .secure_regs_read_only(secure_regs_read_only));

  fsp_engine_model u_fsp_engine_model (
    .clock(clock), .reset(reset), .op_start(op_start), .op_resume(op_resume),
    .op_suspend(op_suspend), .abort(strb[C_PIN] | strb[C_SOFT] | strb[C_PWR]),
    .slow(slow), .engine_done(engine_done));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (op_start === 1'b1) begin
      starts    <= starts + 1;
      last_kind <= op_kind;
      last_addr <= op_addr;
    end
    if (op_suspend === 1'b1) suspends <= suspends + 1;
  end

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle strobe, driven 1 ns after the edge
  task automatic pulse(input int id, input logic [15:0] d, input logic [23:0] a);
    @(posedge clock);
    #1;
    strb[id] = 1'b1;
    wdata = d;
    addr = a;
    @(posedge clock);
    #1;
    strb = 12'h000;
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 100 && status_low[0] !== 1'b0; n++) begin
      @(posedge clock);
      #1;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    finish_test();
  end

  initial begin
    reset = 1'b1; slow = 1'b0; strb = 12'h000; wdata = 16'h0000; addr = 24'h000000;
    starts = 0; mismatches = 0; total_checks = 0; last_kind = 2'h0;
    suspends = 0; last_addr = 24'h000000;
    rows = '{
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h0202, 1'b0, 2'h0},
      '{C_WRDI, 16'h0000, 24'h000000, 16'h0200, 1'b0, 2'h0},
      '{C_SRW,  16'hFFFF, 24'h000000, 16'h0200, 1'b0, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h0202, 1'b0, 2'h0},
      '{C_SRW,  16'h401C, 24'h000000, 16'h421C, 1'b0, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h421E, 1'b0, 2'h0},
      '{C_CE,   16'h0000, 24'h000000, 16'h421C, 1'b1, 2'h3},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h421E, 1'b0, 2'h0},
      '{C_SRW,  16'h4004, 24'h000000, 16'h4204, 1'b0, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h4206, 1'b0, 2'h0},
      '{C_CE,   16'h0000, 24'h000000, 16'h4204, 1'b0, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h4206, 1'b0, 2'h0},
      '{C_SRW,  16'h0018, 24'h000000, 16'h0218, 1'b0, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h021A, 1'b0, 2'h0},
      '{C_PP,   16'h0000, 24'hFFF000, 16'h0218, 1'b0, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h021A, 1'b0, 2'h0},
      '{C_PP,   16'h0000, 24'h000100, 16'h0218, 1'b1, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h021A, 1'b0, 2'h0},
      '{C_CE,   16'h0000, 24'h000000, 16'h0218, 1'b0, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h021A, 1'b0, 2'h0},
      '{C_SRW,  16'h0000, 24'h000000, 16'h0200, 1'b0, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h0202, 1'b0, 2'h0},
      '{C_SE,   16'h0000, 24'h001000, 16'h0200, 1'b1, 2'h1},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h0202, 1'b0, 2'h0},
      '{C_BE,   16'h0000, 24'h010000, 16'h0200, 1'b1, 2'h2},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h0202, 1'b0, 2'h0},
      '{C_SRW,  16'h0800, 24'h000000, 16'h0A00, 1'b0, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h0A02, 1'b0, 2'h0},
      '{C_SRW,  16'h0000, 24'h000000, 16'h0A00, 1'b0, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h0A02, 1'b0, 2'h0},
      '{C_SRW,  16'h0100, 24'h000000, 16'h0B00, 1'b0, 2'h0},
      '{C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000, 16'h0B02, 1'b0, 2'h0},
      '{C_SRW,  16'h001C, 24'h000000, 16'h0B00, 1'b0, 2'h0},
      '{C_PWR,  16'h0000, 24'h000000, 16'h0A00, 1'b0, 2'h0}};
    repeat (3) @(posedge clock);
    #1 reset = 1'b0;
    check16(word, 16'h0200);
    check16({15'h0, upper_pins_enabled}, 16'h0001);
    $display("test reset done");
    foreach (rows[i]) begin
      base = starts;
      pulse(rows[i].cmd, rows[i].data, rows[i].addr);
      wait_idle();
      check16(word, rows[i].word);
      check16(16'(starts - base), {15'h0, rows[i].start});
      if (rows[i].start) check16({14'h0, last_kind}, {14'h0, rows[i].kind});
      if (rows[i].start) check16(last_addr[23:8], rows[i].addr[23:8]);
    end
    check16({13'h0, secure_regs_read_only}, 16'h0001);
    $display("test table done");
    // Busy spans the status write
    pulse(C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000);
    pulse(C_SRW, 16'h0000, 24'h000000);
    check16({15'h0, status_low[0]}, 16'h0001);
    wait_idle();
    check16(word, 16'h0A00);
    // Erase suspend, a status write that tries the flags, then resume
    slow = 1'b1;
    pulse(C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000);
    pulse(C_SE, 16'h0000, 24'h002000);
    check16(word, 16'h0A01);
    pulse(C_SUS, 16'h0000, 24'h000000);
    check16(word, 16'h8A00);
    pulse(C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000);
    pulse(C_SRW, 16'h0400, 24'h000000);
    wait_idle();
    check16(word, 16'h8A00);
    pulse(C_RES, 16'h0000, 24'h000000);
    check16(word, 16'h0A01);
    wait_idle();
    check16(word, 16'h0A00);
    $display("test erase suspend done");
    // Program suspend cleared by software reset, which also drops the latch
    pulse(C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000);
    pulse(C_PP, 16'h0000, 24'h000100);
    pulse(C_SUS, 16'h0000, 24'h000000);
    pulse(C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000);
    check16(word, 16'h0E02);
    pulse(C_SOFT, 16'h0000, 24'h000000);
    check16(word, 16'h0A00);
    check16(16'(suspends), 16'h0002);
    pulse(C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000);
    pulse(C_PIN, 16'h0000, 24'h000000);
    check16(word, 16'h0A00);
    // Permanent lock survives a power cycle
    pulse(C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000);
    pulse(C_SRW, 16'h0180, 24'h000000);
    wait_idle();
    pulse(C_WRITE_ENABLE_CMD, 16'h0000, 24'h000000);
    pulse(C_SRW, 16'h0000, 24'h000000);
    wait_idle();
    pulse(C_PWR, 16'h0000, 24'h000000);
    check16(word, 16'h0B80);
    $display("test lock and reset done");
    finish_test();
  end
endmodule

`default_nettype wire

// ===== verif/fsp_engine_model.sv
// Behavioural array engine that answers the register bank's start and resume pulses.
// Assumes registered one-cycle op_start, op_suspend and op_resume pulses.
`timescale 1ns/1ps
`default_nettype none

module fsp_engine_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Control from the register bank and bench
  input  wire logic op_start,
  input  wire logic op_resume,
  input  wire logic op_suspend,
  input  wire logic abort,
  input  wire logic slow,
  // Completion
  output logic      engine_done
);
  logic       run_q;
  logic [4:0] cnt_q;

  // =========================================================
  // Countdown; suspend freezes it so resume finishes the rest
  always_ff @(posedge clock) begin
    engine_done <= 1'b0;
    if (reset || abort) begin
      run_q <= 1'b0;
      cnt_q <= 5'h00;
    end else if (op_start) begin
      run_q <= 1'b1;
      cnt_q <= slow ? 5'h14 : 5'h02;
    end else if (op_resume) begin
      run_q <= 1'b1;
    end else if (op_suspend) begin
      run_q <= 1'b0;
    end else if (run_q && cnt_q == 5'h00) begin
      engine_done <= 1'b1;
      run_q       <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule

`default_nettype wire
